// File: rtl/lp_rc_tick.sv
// Purpose: Tick at the internal RC oscillator rate from the system clock
// Assumes: System clock is an integer multiple of the RC rate
// Notes:   Counts run while the RC output is enabled
`timescale 1ns/1ps
`default_nettype none
module lp_rc_tick
    import lp_seq_pkg::*;
#(
    parameter int unsigned DIV = RC_DIV
) (
    // Clock and reset
    input  wire logic clk_i,
    input  wire logic resetn_i,
    // Control
    input  wire logic enable_i,
    output logic      tick_o
);
    typedef struct packed {
        logic [7:0] cnt;
        logic       tick;
    } tick_st_t;

    tick_st_t st;
    tick_st_t next_st;

    initial begin
        if (DIV < 1 || DIV > 256) $error("lp_rc_tick: DIV out of range");
    end

    // Divider restarts whenever the RC output is gated
    always_comb begin
        next_st      = st;
        next_st.tick = 1'b0;
        if (!enable_i) begin
            next_st.cnt = 8'h00;
        end else if (st.cnt == 8'(DIV - 1)) begin
            next_st.cnt  = 8'h00;
            next_st.tick = 1'b1;
        end else begin
            next_st.cnt = st.cnt + 8'h01;
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign tick_o = st.tick;
endmodule
`default_nettype wire

// File: rtl/lp_seq_pkg.sv
// Purpose: Shared constants and types for the low-power and reset sequencer
// Assumes: Single 40 MHz clock, internal RC oscillator nominal 4 MHz
// Notes:   Times are kept in their own unit and converted to cycles here
package lp_seq_pkg;
    localparam int unsigned CLK_HZ           = 40_000_000;
    localparam int unsigned RC_HZ            = 4_000_000;
    localparam int unsigned RC_DIV           = CLK_HZ / RC_HZ;
    // Resume counts in source-clock cycles
    localparam int unsigned RC_RESUME_CYC    = 4;
    localparam int unsigned OSC_RESUME_CYC   = 4096;
    // Start-up times in microseconds
    localparam int unsigned RC_START_US      = 60;
    localparam int unsigned FLASH_START_US   = 100;
    localparam int unsigned RC_START_RC      = (RC_START_US * RC_HZ + 999_999) / 1_000_000;
    localparam int unsigned FLASH_START_RC   = (FLASH_START_US * RC_HZ + 999_999) / 1_000_000;
    // Fixed clock count held in reset before release
    localparam int unsigned RESET_HOLD_RC    = 16;
    localparam int unsigned CNT_W            = 14;
    localparam int unsigned IRQ_W            = 8;
    localparam logic [31:0] BOOT_VECTOR      = 32'h0000_0000;
    localparam logic [1:0]  DIV_CLEARED      = 2'h0;

    // Low-power mode requested by the core
    typedef enum logic [1:0] {
        MODE_RUN,
        MODE_DEEP_SLEEP,
        MODE_POWER_DOWN,
        MODE_DEEP_PD
    } lp_mode_t;

    typedef enum logic [2:0] {
        ST_RESET,
        ST_RUN,
        ST_STOPPED,
        ST_RC_START,
        ST_RESUME,
        ST_DEEP_PD
    } seq_state_t;
endpackage

// File: rtl/lp_sequencer.sv
// Purpose: Low-power mode and system reset sequencer
// Assumes: Core requests modes with a one-cycle strobe; pins are asynchronous
// Notes:   Flash and RC-source resume counts run on RC ticks derived from clk_i; main-oscillator resume counts clk edges
//
// Overview of operation
// - Deep-sleep: stop oscillator, gate clocks, retain state
// - Deep-sleep: gate RC output, keep RTC oscillator
// - Deep-sleep entry powers off, disconnects PLL
// - Deep-sleep entry clears cpu and USB dividers
// - Leave deep-sleep only on reset or wake
// - RC source: resume after 4 cycles
// - Main oscillator source: resume after 4096 cycles
// - Power-down adds RC and flash power off
// - Power-down wake: 60 us start, 4 RC cycles
// - Flash blocked until 100 us RC count expires
// - Deep power-down entry only from RTC
// - Deep power-down keeps only RTC, reset pin
// - Exit deep power-down via reset pin, alarm
// - Wake on any interrupt in handed mask
// - Reset sources: pin, watchdog, power-on, brownout
// - Any reset drives reset output low, timer
// - Hold reset until pin, oscillator, count, flash
// - Reset output high on release or brownout recovery
// - Fetch from address 0 after reset release
// - Brownout warning raises interrupt and readable flag
// - Brownout reset held until power-on takes over
`timescale 1ns/1ps
`default_nettype none
module lp_sequencer
    import lp_seq_pkg::*;
#(
    parameter int unsigned N_IRQ       = IRQ_W,
    parameter int unsigned OSC_RESUME  = OSC_RESUME_CYC,
    parameter int unsigned RC_START    = RC_START_RC,
    parameter int unsigned FLASH_START = FLASH_START_RC,
    parameter int unsigned RESET_HOLD  = RESET_HOLD_RC
) (
    // Clock and power-on reset
    input  wire logic             clk_i,
    input  wire logic             resetn_i,
    // Asynchronous reset sources and monitors
    input  wire logic             ext_resetn_i,
    input  wire logic             watchdog_reset_i,
    input  wire logic             brownout_warn_i,
    input  wire logic             brownout_reset_i,
    input  wire logic             osc_running_i,
    // Core low-power request
    input  wire logic             lp_req_i,
    input  wire logic [1:0]       lp_mode_i,
    input  wire logic             main_osc_sel_i,
    // Interrupt controller handoff
    input  wire logic [N_IRQ-1:0] wake_mask_i,
    input  wire logic [N_IRQ-1:0] irq_i,
    // RTC block
    input  wire logic             rtc_deep_pd_req_i,
    input  wire logic             rtc_alarm_i,
    // Flash controller
    input  wire logic             flash_init_done_i,
    // Reset outputs
    output logic                  sys_resetn_o,
    output logic                  reset_output_pin_o,
    output logic [31:0]           boot_addr_o,
    // Clock and power controls
    output logic                  main_osc_en_o,
    output logic                  clk_gate_o,
    output logic                  rc_out_en_o,
    output logic                  rc_power_o,
    output logic                  rtc_osc_en_o,
    output logic                  pll_power_o,
    output logic                  pll_connect_clr_o,
    output logic [1:0]            cpu_clock_div_o,
    output logic [1:0]            usb_clock_div_o,
    output logic                  div_clear_o,
    output logic                  flash_power_o,
    output logic                  flash_ready_o,
    output logic                  core_power_o,
    output logic                  retain_o,
    // Status
    output logic                  cpu_run_o,
    output logic                  brownout_irq_o,
    output logic                  brownout_flag_o,
    output logic [1:0]            mode_o
);
    initial begin
        if (N_IRQ < 1) $error("lp_sequencer: N_IRQ must be at least 1");
        if (OSC_RESUME < 1 || OSC_RESUME >= (1 << CNT_W)) $error("lp_sequencer: OSC_RESUME range");
        if (RC_START < 1 || FLASH_START >= (1 << CNT_W)) $error("lp_sequencer: count range");
        if (RESET_HOLD < 1 || RESET_HOLD >= (1 << CNT_W)) $error("lp_sequencer: RESET_HOLD range");
    end

    localparam logic [CNT_W-1:0] OSC_RESUME_N  = CNT_W'(OSC_RESUME);
    localparam logic [CNT_W-1:0] RC_RESUME_N   = CNT_W'(RC_RESUME_CYC);
    localparam logic [CNT_W-1:0] RC_START_N    = CNT_W'(RC_START);
    localparam logic [CNT_W-1:0] FLASH_START_N = CNT_W'(FLASH_START);
    localparam logic [CNT_W-1:0] RESET_HOLD_N  = CNT_W'(RESET_HOLD);

    // Synchronised asynchronous inputs
    logic [6:0] async_in;
    logic [6:0] sync_in;
    logic       ext_rst_n;
    logic       wdt_rst;
    logic       bo_warn;
    logic       bo_rst;
    logic       osc_ok;
    logic       rtc_alarm;
    logic       rtc_pd_req;

    assign async_in = {rtc_deep_pd_req_i, rtc_alarm_i, osc_running_i, brownout_reset_i,
                       brownout_warn_i, watchdog_reset_i, ext_resetn_i};

    lp_sync2 #(.W(7)) u_sync (
        .clk_i    (clk_i),
        .resetn_i (resetn_i),
        .async_i  (async_in),
        .sync_o   (sync_in)
    );

    assign ext_rst_n  = sync_in[0];
    assign wdt_rst    = sync_in[1];
    assign bo_warn    = sync_in[2];
    assign bo_rst     = sync_in[3];
    assign osc_ok     = sync_in[4];
    assign rtc_alarm  = sync_in[5];
    assign rtc_pd_req = sync_in[6];

    typedef struct packed {
        seq_state_t       state;
        lp_mode_t         mode;
        logic             src_main;
        logic [CNT_W-1:0] cnt;
        logic [CNT_W-1:0] flash_cnt;
        logic             flash_ok;
        logic             rst_out;
        logic             bo_flag;
    } seq_st_t;

    seq_st_t st;
    seq_st_t next_st;
    logic    rc_tick;
    logic    rc_on;
    logic    any_reset;
    logic    wake_irq;
    logic    cnt_tick;

    // Count down one step; stays at zero
    function automatic logic [CNT_W-1:0] dec(input logic [CNT_W-1:0] v);
        return (v == '0) ? v : v - CNT_W'(1);
    endfunction

    // RC output enabled except while clocks are stopped or RC unpowered
    assign rc_on = (st.state != ST_STOPPED) && (st.state != ST_DEEP_PD);

    lp_rc_tick u_tick (
        .clk_i    (clk_i),
        .resetn_i (resetn_i),
        .enable_i (rc_on),
        .tick_o   (rc_tick)
    );

    // Watchdog and brownout are unpowered in deep power-down
    assign any_reset = !ext_rst_n
                    || ((wdt_rst || bo_rst) && st.state != ST_DEEP_PD);
    assign wake_irq  = |(wake_mask_i & irq_i);
    // Main oscillator cycles approximated by clk edges with oscillator up
    assign cnt_tick  = st.src_main ? (osc_ok && st.state == ST_RESUME) : rc_tick;

    // Sequencing of reset, sleep entry and wake
    always_comb begin
        next_st          = st;
        // Flash wake-up counter runs on RC ticks independently of resume
        if (!st.flash_ok && rc_tick && st.state != ST_STOPPED && st.state != ST_DEEP_PD) begin
            next_st.flash_cnt = dec(st.flash_cnt);
            if (st.flash_cnt <= CNT_W'(1)) begin
                next_st.flash_ok = 1'b1;
            end
        end
        // Set wins over software visibility; flag follows warning level
        next_st.bo_flag = bo_warn;
        if (any_reset) begin
            next_st.state   = ST_RESET;
            next_st.cnt     = RESET_HOLD_N;
            next_st.rst_out = 1'b0;
            next_st.mode    = MODE_RUN;
        end else begin
            case (st.state)
                ST_RESET: begin
                    if (rc_tick) begin
                        next_st.cnt = dec(st.cnt);
                    end
                    // Release needs pin, oscillator, count and flash init
                    if (ext_rst_n && osc_ok && st.cnt == '0 && flash_init_done_i) begin
                        next_st.state   = ST_RUN;
                        next_st.rst_out = 1'b1;
                        next_st.src_main = 1'b0;
                    end
                end
                ST_RUN: begin
                    if (rtc_pd_req) begin
                        next_st.state = ST_DEEP_PD;
                        next_st.mode  = MODE_DEEP_PD;
                    end else if (lp_req_i && (lp_mode_i == 2'(MODE_DEEP_SLEEP)
                                 || lp_mode_i == 2'(MODE_POWER_DOWN))) begin
                        next_st.state    = ST_STOPPED;
                        next_st.mode     = lp_mode_t'(lp_mode_i);
                        next_st.src_main = main_osc_sel_i;
                    end
                end
                ST_STOPPED: begin
                    if (wake_irq) begin
                        if (st.mode == MODE_POWER_DOWN) begin
                            next_st.state     = ST_RC_START;
                            next_st.cnt       = RC_START_N;
                            next_st.flash_ok  = 1'b0;
                            next_st.flash_cnt = FLASH_START_N;
                            next_st.src_main  = 1'b0;
                        end else begin
                            next_st.state = ST_RESUME;
                            next_st.cnt   = st.src_main ? OSC_RESUME_N : RC_RESUME_N;
                        end
                    end
                end
                ST_RC_START: begin
                    if (rc_tick) begin
                        next_st.cnt = dec(st.cnt);
                    end
                    if (st.cnt == '0) begin
                        next_st.state = ST_RESUME;
                        next_st.cnt   = RC_RESUME_N;
                    end
                end
                ST_RESUME: begin
                    if (cnt_tick) begin
                        next_st.cnt = dec(st.cnt);
                    end
                    if (st.cnt == '0) begin
                        next_st.state = ST_RUN;
                        next_st.mode  = MODE_RUN;
                    end
                end
                ST_DEEP_PD: begin
                    // Only alarm or reset pin leave; pin is handled above
                    if (rtc_alarm) begin
                        next_st.state   = ST_RESET;
                        next_st.cnt     = RESET_HOLD_N;
                        next_st.rst_out = 1'b0;
                        next_st.mode    = MODE_RUN;
                    end
                end
                default: begin
                    next_st.state = ST_RESET;
                end
            endcase
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            st          <= '0;
            st.state    <= ST_RESET;
            st.mode     <= MODE_RUN;
            st.cnt      <= RESET_HOLD_N;
            st.flash_cnt <= FLASH_START_N;
        end else begin
            st <= next_st;
        end
    end

    // Power and clock controls decoded from state
    logic stopped;
    logic pd_like;
    assign stopped = (st.state == ST_STOPPED);
    assign pd_like = stopped && (st.mode == MODE_POWER_DOWN);

    assign main_osc_en_o      = !stopped && st.state != ST_DEEP_PD;
    assign clk_gate_o         = stopped || st.state == ST_DEEP_PD;
    assign retain_o           = stopped;
    assign rc_out_en_o        = rc_on;
    assign rc_power_o         = !pd_like && st.state != ST_DEEP_PD;
    assign rtc_osc_en_o       = 1'b1;
    assign pll_power_o        = (st.state == ST_RUN);
    assign pll_connect_clr_o  = (st.state != ST_RUN);
    assign div_clear_o        = stopped;
    assign cpu_clock_div_o    = DIV_CLEARED;
    assign usb_clock_div_o    = DIV_CLEARED;
    assign flash_power_o      = !pd_like && st.state != ST_DEEP_PD;
    assign flash_ready_o      = st.flash_ok && flash_power_o;
    assign core_power_o       = (st.state != ST_DEEP_PD);
    assign sys_resetn_o       = (st.state != ST_RESET) && (st.state != ST_DEEP_PD);
    assign reset_output_pin_o = st.rst_out && !bo_rst;
    assign boot_addr_o        = BOOT_VECTOR;
    assign cpu_run_o          = (st.state == ST_RUN);
    assign brownout_irq_o     = st.bo_flag;
    assign brownout_flag_o    = st.bo_flag;
    assign mode_o             = st.mode;

    // Checks
    property p_rc_resume;
        @(posedge clk_i) disable iff (!resetn_i)
        (st.state == ST_STOPPED && wake_irq && !any_reset && st.mode == MODE_DEEP_SLEEP
         && !st.src_main) |=> (st.cnt == RC_RESUME_N);
    endproperty
    a_rc_resume: assert property (p_rc_resume) else $error("bad rc resume count");

    property p_osc_resume;
        @(posedge clk_i) disable iff (!resetn_i)
        (st.state == ST_STOPPED && wake_irq && !any_reset && st.mode == MODE_DEEP_SLEEP
         && st.src_main) |=> (st.cnt == OSC_RESUME_N);
    endproperty
    a_osc_resume: assert property (p_osc_resume) else $error("bad osc resume count");

    property p_reset_low;
        @(posedge clk_i) disable iff (!resetn_i)
        any_reset |=> !reset_output_pin_o && !sys_resetn_o;
    endproperty
    a_reset_low: assert property (p_reset_low) else $error("reset output not low");

    property p_release;
        @(posedge clk_i) disable iff (!resetn_i)
        $rose(sys_resetn_o) && $past(st.state) == ST_RESET |->
            $past(ext_rst_n) && $past(osc_ok) && $past(flash_init_done_i);
    endproperty
    a_release: assert property (p_release) else $error("early reset release");

    property p_stay_stopped;
        @(posedge clk_i) disable iff (!resetn_i)
        (stopped && !wake_irq && !any_reset && !rtc_pd_req) |=> stopped;
    endproperty
    a_stay_stopped: assert property (p_stay_stopped) else $error("spurious wake");

    property p_pd_power;
        @(posedge clk_i) disable iff (!resetn_i)
        pd_like |-> !rc_power_o && !flash_power_o && !pll_power_o;
    endproperty
    a_pd_power: assert property (p_pd_power) else $error("power-down leaves power on");

    property p_ds_power;
        @(posedge clk_i) disable iff (!resetn_i)
        (stopped && st.mode == MODE_DEEP_SLEEP) |-> flash_power_o && rc_power_o
            && !rc_out_en_o && !main_osc_en_o && div_clear_o;
    endproperty
    a_ds_power: assert property (p_ds_power) else $error("deep-sleep power wrong");

    property p_flash_block;
        @(posedge clk_i) disable iff (!resetn_i)
        (st.state == ST_STOPPED && st.mode == MODE_POWER_DOWN && wake_irq && !any_reset)
            |=> !flash_ready_o [*8];
    endproperty
    a_flash_block: assert property (p_flash_block) else $error("flash ready too soon");

    property p_deep_pd_entry;
        @(posedge clk_i) disable iff (!resetn_i)
        $rose(st.state == ST_DEEP_PD) |-> $past(rtc_pd_req);
    endproperty
    a_deep_pd_entry: assert property (p_deep_pd_entry) else $error("deep pd not from rtc");

    property p_bo_hold;
        @(posedge clk_i) disable iff (!resetn_i)
        bo_rst |-> !reset_output_pin_o ##1 !sys_resetn_o;
    endproperty
    a_bo_hold: assert property (p_bo_hold) else $error("brownout reset released");

    c_ds_wake: cover property (@(posedge clk_i) disable iff (!resetn_i)
        stopped && st.mode == MODE_DEEP_SLEEP ##1 st.state == ST_RESUME);
    c_pd_wake: cover property (@(posedge clk_i) disable iff (!resetn_i)
        st.state == ST_RC_START ##[1:1000] st.state == ST_RUN);
    c_deep_pd: cover property (@(posedge clk_i) disable iff (!resetn_i)
        st.state == ST_DEEP_PD ##1 st.state == ST_RESET);
endmodule
`default_nettype wire

// File: rtl/lp_sync2.sv
// Purpose: Two-flop synchroniser for a bundle of asynchronous levels
// Assumes: Inputs are slow levels, not pulses
// Notes:   First stage is read only by the second stage
`timescale 1ns/1ps
`default_nettype none
module lp_sync2 #(
    parameter int unsigned W = 1
) (
    // Clock and reset
    input  wire logic         clk_i,
    input  wire logic         resetn_i,
    // Levels
    input  wire logic [W-1:0] async_i,
    output logic      [W-1:0] sync_o
);
    logic [W-1:0] meta;

    // Plain two-stage chain
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            meta   <= '0;
            sync_o <= '0;
        end else begin
            meta   <= async_i;
            sync_o <= meta;
        end
    end
endmodule
`default_nettype wire

// File: tb/lp_core_model.sv
// Purpose: Core and interrupt controller seen from the sequencer
// Assumes: Bench asks for sleep by holding sleep_i high
// Notes:   Mask is handed over only while clocks are stopped
`timescale 1ns/1ps
`default_nettype none
module lp_core_model
    import lp_seq_pkg::*;
#(
    parameter int unsigned N = IRQ_W
) (
    // Clock and reset
    input  wire logic         clk_i,
    input  wire logic         resetn_i,
    // Sequencer status
    input  wire logic         cpu_run_i,
    input  wire logic         stopped_i,
    // Bench commands
    input  wire logic         sleep_i,
    input  wire logic [1:0]   mode_i,
    input  wire logic [N-1:0] enabled_i,
    // Toward the sequencer
    output logic              lp_req_o,
    output logic [1:0]        lp_mode_o,
    output logic [N-1:0]      wake_mask_o
);
    logic sent;

    // One strobe per command, only while the core runs
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            lp_req_o    <= 1'b0;
            lp_mode_o   <= 2'h0;
            sent        <= 1'b0;
            wake_mask_o <= '0;
        end else begin
            lp_req_o    <= sleep_i && cpu_run_i && !sent;
            lp_mode_o   <= mode_i;
            sent        <= sleep_i && (sent || cpu_run_i);
            wake_mask_o <= stopped_i ? enabled_i : '0;
        end
    end
endmodule
`default_nettype wire

// File: tb/lp_sequencer_tb.sv
// Purpose: Self-checking bench for the low-power sequencer
// Assumes: Shortened counts; one RC tick is ten clocks
// Notes:   Wake windows allow a few cycles of sync slack
`timescale 1ns/1ps
`default_nettype none
module lp_sequencer_tb;
    import lp_seq_pkg::*;
    logic clk_i = 0, resetn_i = 0, ext_n = 1, wdt = 0, bo_w = 0, bo_r = 0, osc = 0;
    logic sel = 0, pdr = 0, alm = 0, fdone = 0, sleep = 0, req;
    logic [1:0] mode = 2'h0, lpm, cdiv, udiv, mo;
    logic [7:0] ena = 8'h02, irq = 8'h00, mask;
    logic [31:0] boot;
    logic srst, rpin, gate, rce, rcp, rtco, pll, dclr, fpw, frdy, core, ret, run, bi, bf;
    logic mosc, pcc;
    int miscompares = 0, tests_run = 0, n;

    // Clock at 40 MHz
    initial forever #12.5 clk_i = ~clk_i;

    lp_sequencer #(.OSC_RESUME(8), .RC_START(4), .FLASH_START(12), .RESET_HOLD(2)) i_dut (
        .clk_i(clk_i), .resetn_i(resetn_i), .ext_resetn_i(ext_n), .watchdog_reset_i(wdt),
        .brownout_warn_i(bo_w), .brownout_reset_i(bo_r), .osc_running_i(osc),
        .lp_req_i(req), .lp_mode_i(lpm), .main_osc_sel_i(sel), .wake_mask_i(mask),
        .irq_i(irq), .rtc_deep_pd_req_i(pdr), .rtc_alarm_i(alm),
        .flash_init_done_i(fdone), .sys_resetn_o(srst), .reset_output_pin_o(rpin),
        .boot_addr_o(boot), .main_osc_en_o(mosc), .clk_gate_o(gate), .rc_out_en_o(rce),
        .rc_power_o(rcp), .rtc_osc_en_o(rtco), .pll_power_o(pll), .pll_connect_clr_o(pcc),
        .cpu_clock_div_o(cdiv), .usb_clock_div_o(udiv), .div_clear_o(dclr),
        .flash_power_o(fpw), .flash_ready_o(frdy), .core_power_o(core), .retain_o(ret),
        .cpu_run_o(run), .brownout_irq_o(bi), .brownout_flag_o(bf), .mode_o(mo));

    lp_core_model i_core (.clk_i(clk_i), .resetn_i(resetn_i), .cpu_run_i(run),
        .stopped_i(gate), .sleep_i(sleep), .mode_i(mode), .enabled_i(ena),
        .lp_req_o(req), .lp_mode_o(lpm), .wake_mask_o(mask));

    // Report and stop; also reached from the watchdog
    task automatic complete_run;
        $display("compares %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        tests_run++;
        if (g !== e) begin
            miscompares++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask

    // Sample one step after the edge so updates have landed
    task automatic cyc(input int k);
        repeat (k) @(posedge clk_i);
        #1;
    endtask

    task automatic wait_run(input int lim);
        n = 0;
        while (run !== 1'b1 && n < lim) begin
            cyc(1);
            n++;
        end
        // A run that never comes is a mismatch on its own
        if (run !== 1'b1) miscompares++;
    endtask

    task automatic ask(input logic [1:0] m);
        @(posedge clk_i);
        sleep <= 1'b1;
        mode  <= m;
        repeat (3) @(posedge clk_i);
        sleep <= 1'b0;
        cyc(2);
    endtask

    // Power-on: held until flash init completes and the oscillator is up
    task automatic t_reset;
        cyc(16);
        chk(rpin, 0);
        @(posedge clk_i);
        resetn_i <= 1'b1;
        cyc(60);
        chk(srst, 0);
        @(posedge clk_i);
        fdone <= 1'b1;
        cyc(60);
        chk(srst, 0);
        @(posedge clk_i);
        osc <= 1'b1;
        wait_run(100);
        chk({srst, rpin, run}, 3'h7);
        chk(boot, 32'h0000_0000);
    endtask

    // Stop, reject an irq outside the wake mask, then wake within lo..hi cycles
    task automatic t_sleep(input logic [1:0] m, input logic s, input int lo, input int hi);
        logic ds;
        ds = (m == 2'h1);
        @(posedge clk_i);
        sel <= s;
        ask(m);
        chk({gate, ret, pll, rce, rtco, mosc, pcc}, 7'h65);
        chk({dclr, cdiv, udiv}, 5'h10);
        chk({rcp, fpw, mo}, {ds, ds, m});
        @(posedge clk_i);
        irq <= 8'h01;
        cyc(60);
        chk(run, 0);
        @(posedge clk_i);
        irq <= 8'h02;
        wait_run(200);
        chk((n >= lo) && (n <= hi), 1);
        chk({pcc, cdiv, udiv}, 5'h00);
        @(posedge clk_i);
        irq <= 8'h00;
        if (!ds) begin
            n = 0;
            while (frdy !== 1'b1 && n < 200) begin
                cyc(1);
                n++;
            end
            chk(n >= 30 && n <= 45, 1);
        end
    endtask

    // Deep power-down: refused from the core, exits by alarm and pin
    task automatic t_deep_pd;
        ask(2'h3);
        chk({core, gate}, 2'h2);
        for (int i = 0; i < 2; i++) begin
            @(posedge clk_i);
            pdr <= 1'b1;
            cyc(6);
            chk({core, rtco, mo}, 4'h7);
            @(posedge clk_i);
            pdr <= 1'b0;
            irq <= 8'hff;
            wdt <= 1'b1;
            cyc(30);
            chk(core, 0);
            @(posedge clk_i);
            irq   <= 8'h00;
            wdt   <= 1'b0;
            alm   <= (i == 0);
            ext_n <= (i == 0);
            cyc(6);
            @(posedge clk_i);
            alm   <= 1'b0;
            ext_n <= 1'b1;
            wait_run(200);
            chk(run, 1);
        end
    endtask

    // Watchdog and two-stage brownout
    task automatic t_sources;
        @(posedge clk_i);
        wdt <= 1'b1;
        cyc(5);
        chk({srst, rpin}, 2'h0);
        @(posedge clk_i);
        wdt <= 1'b0;
        wait_run(200);
        @(posedge clk_i);
        bo_w <= 1'b1;
        cyc(5);
        chk({bi, bf, run}, 3'h7);
        @(posedge clk_i);
        bo_r <= 1'b1;
        cyc(5);
        chk({srst, rpin}, 2'h0);
        @(posedge clk_i);
        bo_r <= 1'b0;
        bo_w <= 1'b0;
        wait_run(200);
        chk({rpin, bf}, 2'h2);
    endtask

    initial begin
        t_reset;
        t_sleep(2'h1, 1'b0, 30, 55);
        t_sleep(2'h1, 1'b1, 4, 16);
        t_sleep(2'h2, 1'b0, 70, 100);
        t_deep_pd;
        t_sources;
        complete_run;
    end

    // Watchdog on a hung run
    initial begin
        cyc(20000);
        miscompares++;
        complete_run;
    end
endmodule
`default_nettype wire
